/* File: common/hs_timer_pkg.sv */
// Package: register map, field layout, codes and timing for the switch/timer block
package hs_timer_pkg;

    // ==========================================================
    // Register addresses (7-bit serial frame address)
    localparam logic [6:0] ADDR_TIMER1 = 7'h0c;
    localparam logic [6:0] ADDR_TIMER2 = 7'h0d;
    localparam logic [6:0] ADDR_SHUTDOWN = 7'h10;
    localparam logic [6:0] ADDR_SRC_LOW = 7'h14;
    localparam logic [6:0] ADDR_SRC_HIGH = 7'h15;
    localparam logic [6:0] ADDR_PWM1_DUTY = 7'h18;
    localparam logic [6:0] ADDR_PWM2_DUTY = 7'h19;
    localparam logic [6:0] ADDR_PWM_RATE = 7'h1c;

    // ==========================================================
    // Reset values and writable-bit masks
    localparam logic [7:0] TIMER_RST = 8'h00;
    localparam logic [7:0] SD_RST = 8'h00;
    localparam logic [7:0] SRC_RST = 8'h00;
    localparam logic [7:0] PWM_RST = 8'h00;
    localparam logic [7:0] TIMER_WMASK = 8'h77;
    localparam logic [7:0] SD_WMASK = 8'h70;
    localparam logic [7:0] SRC_WMASK = 8'h77;
    localparam logic [7:0] RATE_WMASK = 8'h05;
    localparam logic [7:0] DUTY_FULL = 8'hff;

    // ==========================================================
    // Field positions
    localparam int unsigned ON_LSB = 4;
    localparam int unsigned PER_LSB = 0;
    localparam int unsigned SD_OV_DIS_BIT = 6;
    localparam int unsigned SD_UV_DIS_BIT = 5;
    localparam int unsigned SD_REC_BIT = 4;
    localparam int unsigned RATE1_BIT = 0;
    localparam int unsigned RATE2_BIT = 2;
    localparam int unsigned SRC_STRIDE = 4;

    // ==========================================================
    // Codes
    typedef enum logic [2:0] {
        SRC_OFF = 3'b000,
        SRC_ON = 3'b001,
        SRC_TIMER1 = 3'b010,
        SRC_TIMER2 = 3'b011,
        SRC_PWM1 = 3'b100,
        SRC_PWM2 = 3'b101
    } src_sel_e;
    localparam logic [2:0] ON_STOP_LOW = 3'b000;
    localparam logic [2:0] ON_STOP_HIGH = 3'b110;
    localparam logic [2:0] ON_RESERVED = 3'b111;
    localparam logic [2:0] PER_RESERVED = 3'b111;

    typedef enum logic [1:0] {
        TMR_STOP_LOW = 2'b00,
        TMR_STOP_HIGH = 2'b01,
        TMR_RUN = 2'b10
    } tmr_state_e;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned TICK_NS = 100000;
    localparam int unsigned TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PWM_STEPS = 255;
    localparam int unsigned PWM_SLOW_PERIOD_NS = 5000000;
    localparam int unsigned PWM_FAST_PERIOD_NS = 2500000;
    localparam int unsigned PWM_SLOW_STEP_CYC = PWM_SLOW_PERIOD_NS / (CLK_PERIOD_NS * PWM_STEPS);
    localparam int unsigned PWM_FAST_STEP_CYC = PWM_FAST_PERIOD_NS / (CLK_PERIOD_NS * PWM_STEPS);

    // ==========================================================
    // Register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // On-time in 0.1 ms ticks
    function automatic logic [14:0] on_ticks(input logic [2:0] code);
        case (code)
            3'b001: on_ticks = 15'd1;
            3'b010: on_ticks = 15'd3;
            3'b011: on_ticks = 15'd10;
            3'b100: on_ticks = 15'd100;
            3'b101: on_ticks = 15'd200;
            default: on_ticks = 15'd0;
        endcase
    endfunction : on_ticks

    // Period in 0.1 ms ticks
    function automatic logic [14:0] per_ticks(input logic [2:0] code);
        case (code)
            3'b000: per_ticks = 15'd100;
            3'b001: per_ticks = 15'd200;
            3'b010: per_ticks = 15'd500;
            3'b011: per_ticks = 15'd1000;
            3'b100: per_ticks = 15'd2000;
            3'b101: per_ticks = 15'd10000;
            3'b110: per_ticks = 15'd20000;
            default: per_ticks = 15'd0;
        endcase
    endfunction : per_ticks

endpackage : hs_timer_pkg

/* File: logic/cyclic_timer.sv */
// Cyclic timer: period and on-time decode, output level for assigned switches
`timescale 1ns/1ps
module cyclic_timer import hs_timer_pkg::*; #(
    parameter int unsigned tick_cycles_p = TICK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] on_code_i,
    input wire logic [2:0] per_code_i,
    output logic level_o,
    output logic running_o
);

    tmr_state_e state_r, state_nxt;
    logic [11:0] pre_r, pre_nxt;
    logic [14:0] cnt_r, cnt_nxt;
    logic level_r, level_nxt;
    logic running_r, running_nxt;

    // ==========================================================
    // Next state
    always_comb begin
        state_nxt = TMR_STOP_LOW;
        if (on_code_i == ON_STOP_HIGH) begin
            state_nxt = TMR_STOP_HIGH;
        end else if (on_code_i != ON_STOP_LOW && on_code_i != ON_RESERVED && per_code_i != PER_RESERVED) begin
            state_nxt = TMR_RUN;
        end
        pre_nxt = 12'h000;
        cnt_nxt = 15'h0000;
        level_nxt = (state_nxt == TMR_STOP_HIGH);
        running_nxt = (state_nxt == TMR_RUN);
        if (state_nxt == TMR_RUN && state_r == TMR_RUN) begin
            pre_nxt = pre_r + 12'h001;
            cnt_nxt = cnt_r;
            if (pre_r >= 12'(tick_cycles_p - 1)) begin
                pre_nxt = 12'h000;
                // Period may shrink while running, so wrap on >=
                cnt_nxt = (cnt_r >= per_ticks(per_code_i) - 15'h0001) ? 15'h0000 : cnt_r + 15'h0001;
            end
            level_nxt = (cnt_nxt < on_ticks(on_code_i));
        end else if (state_nxt == TMR_RUN) begin
            level_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= TMR_STOP_LOW;
            pre_r <= 12'h000;
            cnt_r <= 15'h0000;
            level_r <= 1'b0;
            running_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            level_r <= level_nxt;
            running_r <= running_nxt;
        end
    end

    assign level_o = level_r;
    assign running_o = running_r;

    // ==========================================================
    // Checks
    property p_stop_low;
        @(posedge clk_i) disable iff (rst_i)
        (on_code_i == ON_STOP_LOW) |=> (!level_o && !running_o);
    endproperty
    a_stop_low: assert property (p_stop_low) else $error("stopped-low timer drives high");

    property p_stop_high;
        @(posedge clk_i) disable iff (rst_i)
        (on_code_i == ON_STOP_HIGH) |=> (level_o && !running_o);
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("stopped-high timer drives low");

    property p_start_high;
        @(posedge clk_i) disable iff (rst_i)
        $rose(running_o) |-> level_o ##1 (level_o || !running_o);
    endproperty
    a_start_high: assert property (p_start_high) else $error("timer period did not start with on-time");

endmodule : cyclic_timer

/* File: logic/high_side_switch_timer_ctrl.sv */
// High-side switch source selection, cyclic timers, PWM and supply shutdown
//
// Behaviour
// - Timer on-time code 000 stops the timer, assigned switches low.
// - Timer on-time code 110 stops the timer, assigned switches high; 111 reserved.
// - On-time code 001..101 gives 0.1, 0.3, 1.0, 10, 20 ms.
// - Period code 000..110 gives 10, 20, 50, 100, 200 ms, 1 s, 2 s.
// - Software assigns a timer first; writing a running on-time starts it.
// - Restart with cyclic sensing also clears timer period and on-time.
// - Reserved bits read zero and ignore writes.
// - Second timer register clears on power-on, soft reset and restart.
// - Shutdown bit 6 zero: supply overvoltage turns all four switches off.
// - Shutdown bit 5 zero: supply undervoltage turns all four switches off.
// - Shutdown bit 4 one restores switches after fault, zero keeps them off.
// - Shutdown register clears on reset; restart keeps only bits 6:4.
// - Source codes: off, on, timer1, timer2, PWM1, PWM2; 110/111 reserved.
// - Switches 1,2 at bits 2:0 and 6:4 of low register; 3,4 high.
// - Overcurrent or overtemperature clears that switch's source field.
// - Both source registers clear on power-on, soft reset and restart.
// - First timer uses the same encodings in its own register.
// - PWM duty of 255 steps: 0 always off, 255 always on.
// - PWM runs at 200 Hz with rate bit 0, 400 Hz with 1.
`timescale 1ns/1ps
module high_side_switch_timer_ctrl import hs_timer_pkg::*; #(
    parameter int unsigned tick_cycles_p = TICK_CYC,
    parameter int unsigned pwm_slow_step_p = PWM_SLOW_STEP_CYC,
    parameter int unsigned pwm_fast_step_p = PWM_FAST_STEP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic soft_reset_i,
    input wire logic restart_i,
    input wire reg_req_s reg_req_i,
    input wire logic supply_overvolt_i,
    input wire logic supply_undervolt_i,
    input wire logic [3:0] switch_fault_i,
    output logic [7:0] rdata_o,
    output logic [3:0] high_side_output_o,
    output logic [1:0] timer_running_o
);

    // ==========================================================
    // Registers
    logic [7:0] first_timer_r, first_timer_nxt;
    logic [7:0] second_timer_r, second_timer_nxt;
    logic [7:0] shutdown_r, shutdown_nxt;
    logic [7:0] src_low_r, src_low_nxt;
    logic [7:0] src_high_r, src_high_nxt;
    logic [7:0] first_pwm_duty_r, first_pwm_duty_nxt;
    logic [7:0] second_pwm_duty_r, second_pwm_duty_nxt;
    logic [7:0] pwm_rate_r, pwm_rate_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic supply_shut_r, supply_shut_nxt;
    logic supply_shut_now;
    logic recover_clear;

    function automatic logic [7:0] fault_keep(input logic [1:0] fault);
        fault_keep = ~{1'b0, {3{fault[1]}}, 1'b0, {3{fault[0]}}};
    endfunction : fault_keep

    always_comb begin
        supply_shut_now = (supply_overvolt_i && !shutdown_r[SD_OV_DIS_BIT]) ||
            (supply_undervolt_i && !shutdown_r[SD_UV_DIS_BIT]);
        supply_shut_nxt = supply_shut_now;
        // Without recovery the fault is made permanent by dropping the sources
        recover_clear = supply_shut_r && !supply_shut_now && !shutdown_r[SD_REC_BIT];

        first_timer_nxt = first_timer_r;
        second_timer_nxt = second_timer_r;
        shutdown_nxt = shutdown_r;
        src_low_nxt = src_low_r;
        src_high_nxt = src_high_r;
        first_pwm_duty_nxt = first_pwm_duty_r;
        second_pwm_duty_nxt = second_pwm_duty_r;
        pwm_rate_nxt = pwm_rate_r;

        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                ADDR_TIMER1: first_timer_nxt = reg_req_i.wdata & TIMER_WMASK;
                ADDR_TIMER2: second_timer_nxt = reg_req_i.wdata & TIMER_WMASK;
                ADDR_SHUTDOWN: shutdown_nxt = reg_req_i.wdata & SD_WMASK;
                ADDR_SRC_LOW: src_low_nxt = reg_req_i.wdata & SRC_WMASK;
                ADDR_SRC_HIGH: src_high_nxt = reg_req_i.wdata & SRC_WMASK;
                ADDR_PWM1_DUTY: first_pwm_duty_nxt = reg_req_i.wdata;
                ADDR_PWM2_DUTY: second_pwm_duty_nxt = reg_req_i.wdata;
                ADDR_PWM_RATE: pwm_rate_nxt = reg_req_i.wdata & RATE_WMASK;
                default: ;
            endcase
        end

        // Hardware clears beat a simultaneous software write
        src_low_nxt = src_low_nxt & fault_keep(switch_fault_i[1:0]);
        src_high_nxt = src_high_nxt & fault_keep(switch_fault_i[3:2]);
        if (recover_clear) begin
            src_low_nxt = SRC_RST;
            src_high_nxt = SRC_RST;
        end

        if (soft_reset_i) begin
            first_timer_nxt = TIMER_RST;
            second_timer_nxt = TIMER_RST;
            shutdown_nxt = SD_RST;
            src_low_nxt = SRC_RST;
            src_high_nxt = SRC_RST;
            first_pwm_duty_nxt = PWM_RST;
            second_pwm_duty_nxt = PWM_RST;
            pwm_rate_nxt = PWM_RST;
        end else if (restart_i) begin
            // Timers are cleared with the sources so cyclic sensing never sees a stale switch
            first_timer_nxt = TIMER_RST;
            second_timer_nxt = TIMER_RST;
            shutdown_nxt = shutdown_r & SD_WMASK;
            src_low_nxt = SRC_RST;
            src_high_nxt = SRC_RST;
            pwm_rate_nxt = pwm_rate_r & RATE_WMASK;
        end

        rdata_nxt = rdata_r;
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                ADDR_TIMER1: rdata_nxt = first_timer_r;
                ADDR_TIMER2: rdata_nxt = second_timer_r;
                ADDR_SHUTDOWN: rdata_nxt = shutdown_r;
                ADDR_SRC_LOW: rdata_nxt = src_low_r;
                ADDR_SRC_HIGH: rdata_nxt = src_high_r;
                ADDR_PWM1_DUTY: rdata_nxt = first_pwm_duty_r;
                ADDR_PWM2_DUTY: rdata_nxt = second_pwm_duty_r;
                ADDR_PWM_RATE: rdata_nxt = pwm_rate_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_timer_r <= TIMER_RST;
            second_timer_r <= TIMER_RST;
            shutdown_r <= SD_RST;
            src_low_r <= SRC_RST;
            src_high_r <= SRC_RST;
            first_pwm_duty_r <= PWM_RST;
            second_pwm_duty_r <= PWM_RST;
            pwm_rate_r <= PWM_RST;
            rdata_r <= 8'h00;
            supply_shut_r <= 1'b0;
        end else begin
            first_timer_r <= first_timer_nxt;
            second_timer_r <= second_timer_nxt;
            shutdown_r <= shutdown_nxt;
            src_low_r <= src_low_nxt;
            src_high_r <= src_high_nxt;
            first_pwm_duty_r <= first_pwm_duty_nxt;
            second_pwm_duty_r <= second_pwm_duty_nxt;
            pwm_rate_r <= pwm_rate_nxt;
            rdata_r <= rdata_nxt;
            supply_shut_r <= supply_shut_nxt;
        end
    end

    assign rdata_o = rdata_r;

    // ==========================================================
    // Cyclic timers
    logic [1:0] timer_level;
    logic [1:0] timer_run;

    cyclic_timer #(
        .tick_cycles_p(tick_cycles_p)
    ) u_first_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .on_code_i(first_timer_r[ON_LSB +: 3]),
        .per_code_i(first_timer_r[PER_LSB +: 3]),
        .level_o(timer_level[0]),
        .running_o(timer_run[0])
    );

    cyclic_timer #(
        .tick_cycles_p(tick_cycles_p)
    ) u_second_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .on_code_i(second_timer_r[ON_LSB +: 3]),
        .per_code_i(second_timer_r[PER_LSB +: 3]),
        .level_o(timer_level[1]),
        .running_o(timer_run[1])
    );

    assign timer_running_o = timer_run;

    // ==========================================================
    // PWM channels
    // Step length rounds down, so a period runs slightly short of nominal
    logic [1:0][8:0] pwm_pre_r, pwm_pre_nxt;
    logic [1:0][7:0] pwm_pos_r, pwm_pos_nxt;
    logic [1:0] pwm_level_r, pwm_level_nxt;
    logic [1:0][7:0] pwm_duty;
    logic [1:0] pwm_fast;

    always_comb begin
        pwm_duty = {second_pwm_duty_r, first_pwm_duty_r};
        pwm_fast = {pwm_rate_r[RATE2_BIT], pwm_rate_r[RATE1_BIT]};
        for (int i = 0; i < 2; i++) begin
            pwm_pre_nxt[i] = pwm_pre_r[i] + 9'h001;
            pwm_pos_nxt[i] = pwm_pos_r[i];
            if (pwm_pre_r[i] >= (pwm_fast[i] ? 9'(pwm_fast_step_p - 1) : 9'(pwm_slow_step_p - 1))) begin
                pwm_pre_nxt[i] = 9'h000;
                pwm_pos_nxt[i] = (pwm_pos_r[i] >= 8'(PWM_STEPS - 1)) ? 8'h00 : pwm_pos_r[i] + 8'h01;
            end
            // Position never reaches 255, so full duty stays on and zero stays off
            pwm_level_nxt[i] = (pwm_pos_nxt[i] < pwm_duty[i]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_pre_r <= '0;
            pwm_pos_r <= '0;
            pwm_level_r <= 2'b00;
        end else begin
            pwm_pre_r <= pwm_pre_nxt;
            pwm_pos_r <= pwm_pos_nxt;
            pwm_level_r <= pwm_level_nxt;
        end
    end

    // ==========================================================
    // Switch outputs
    logic [3:0] hs_on_r, hs_on_nxt;
    logic [15:0] src_all;
    logic [2:0] src_code;

    always_comb begin
        src_all = {src_high_r, src_low_r};
        src_code = SRC_OFF;
        for (int i = 0; i < 4; i++) begin
            src_code = src_all[SRC_STRIDE * i +: 3];
            case (src_code)
                SRC_OFF: hs_on_nxt[i] = 1'b0;
                SRC_ON: hs_on_nxt[i] = 1'b1;
                SRC_TIMER1: hs_on_nxt[i] = timer_level[0];
                SRC_TIMER2: hs_on_nxt[i] = timer_level[1];
                SRC_PWM1: hs_on_nxt[i] = pwm_level_r[0];
                SRC_PWM2: hs_on_nxt[i] = pwm_level_r[1];
                default: hs_on_nxt[i] = 1'b0;
            endcase
            // Sources still hold their old code in the cycle they are dropped
            if (switch_fault_i[i] || supply_shut_now || recover_clear) begin
                hs_on_nxt[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hs_on_r <= 4'h0;
        end else begin
            hs_on_r <= hs_on_nxt;
        end
    end

    assign high_side_output_o = hs_on_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_sd_reserved_read;
        (reg_req_i.rd && reg_req_i.addr == ADDR_SHUTDOWN) |=> (rdata_o[7] == 1'b0 && rdata_o[3:0] == 4'h0);
    endproperty
    a_sd_reserved_read: assert property (p_sd_reserved_read) else $error("shutdown reserved bits read nonzero");

    property p_timer2_clear;
        (soft_reset_i || restart_i) |=> (second_timer_r == TIMER_RST && first_timer_r == TIMER_RST);
    endproperty
    a_timer2_clear: assert property (p_timer2_clear) else $error("timer register not cleared");

    property p_sd_restart;
        (restart_i && !soft_reset_i) |=> (shutdown_r == ($past(shutdown_r) & SD_WMASK));
    endproperty
    a_sd_restart: assert property (p_sd_restart) else $error("shutdown register wrong after restart");

    property p_ov_off;
        (supply_overvolt_i && !shutdown_r[SD_OV_DIS_BIT]) |=> (high_side_output_o == 4'h0);
    endproperty
    a_ov_off: assert property (p_ov_off) else $error("switch on during overvoltage");

    property p_uv_off;
        (supply_undervolt_i && !shutdown_r[SD_UV_DIS_BIT]) |=> (high_side_output_o == 4'h0);
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("switch on during undervoltage");

    property p_fault_clear;
        switch_fault_i[0] |=> (src_low_r[2:0] == 3'b000 && !high_side_output_o[0]);
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("faulted switch source not cleared");

    property p_src_reset;
        (soft_reset_i || restart_i) |=> (src_low_r == SRC_RST && src_high_r == SRC_RST);
    endproperty
    a_src_reset: assert property (p_src_reset) else $error("source registers not cleared");

    property p_no_recover;
        recover_clear && !soft_reset_i |=> (src_low_r == SRC_RST && src_high_r == SRC_RST &&
            high_side_output_o == 4'h0);
    endproperty
    a_no_recover: assert property (p_no_recover) else $error("switches kept after fault without recovery");

    sequence s_both_on_write;
        reg_req_i.wr && reg_req_i.addr == ADDR_SRC_LOW && reg_req_i.wdata == 8'h11 &&
            !soft_reset_i && !restart_i && switch_fault_i[1:0] == 2'b00 && !recover_clear;
    endsequence
    sequence s_quiet;
        !supply_shut_now && switch_fault_i[1:0] == 2'b00;
    endsequence
    property p_src_on;
        s_both_on_write ##1 s_quiet |=> (high_side_output_o[1:0] == 2'b11);
    endproperty
    a_src_on: assert property (p_src_on) else $error("switches one and two not on");

endmodule : high_side_switch_timer_ctrl

/* File: test/host_model.sv */
// Host model: register writes and reads towards the block
`timescale 1ns/1ps
module host_model import hs_timer_pkg::*; (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output reg_req_s req_o
);
    initial req_o = '0;
    // ==========================================================
    // Request held up to the taking edge, then dropped
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        #1 req_o = '0;
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        #1 req_o = '0;
        @(posedge clk_i);
        #1 d = rdata_i;
    endtask : rd
endmodule : host_model

/* File: test/testbench.sv */
// Testbench: register map, sources, supply shutdown and timer
`timescale 1ns/1ps
module testbench import hs_timer_pkg::*;;
    logic clk_i, rst_i, soft_i, rs_i, ov_i, uv_i;
    logic [3:0] flt_i, hso;
    logic [1:0] trun;
    logic [7:0] rdata, v;
    reg_req_s req;
    int err_total = 0;
    int n_compared = 0;
    int hi, lo, nr;
    logic pv;
    typedef struct packed {logic [6:0] a; logic [7:0] d; logic [7:0] e;} row_s;
    row_s rows [8] = '{'{ADDR_TIMER1, 8'hff, 8'h77}, '{ADDR_TIMER2, 8'hff, 8'h77},
        '{ADDR_SHUTDOWN, 8'hff, 8'h70}, '{ADDR_SRC_LOW, 8'hff, 8'h77},
        '{ADDR_SRC_HIGH, 8'h88, 8'h00}, '{7'h20, 8'hff, 8'h00},
        '{ADDR_PWM1_DUTY, 8'h5a, 8'h5a}, '{ADDR_PWM_RATE, 8'hff, 8'h05}};
    high_side_switch_timer_ctrl #(.tick_cycles_p(4), .pwm_slow_step_p(3), .pwm_fast_step_p(2)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .soft_reset_i(soft_i), .restart_i(rs_i), .reg_req_i(req),
        .supply_overvolt_i(ov_i), .supply_undervolt_i(uv_i), .switch_fault_i(flt_i),
        .rdata_o(rdata), .high_side_output_o(hso), .timer_running_o(trun));
    host_model host (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // ==========================================================
    // Watchdog: tests need about 2500 cycles
    initial begin
        #2ms;
        err_total++;
        final_report();
    end
    initial begin
        {rst_i, soft_i, rs_i, ov_i, uv_i, flt_i} = {1'b1, 8'h00};
        step(16);
        rst_i = 1'b0;
        chk({4'h0, hso}, 8'h00);
        foreach (rows[i]) begin
            host.wr(rows[i].a, rows[i].d);
            host.rd(rows[i].a, v);
            chk(v, rows[i].e);
        end
        chk({4'h0, hso}, 8'h00);
        $display("test register map done");
        rs_i = 1'b1;
        step(1);
        rs_i = 1'b0;
        host.rd(ADDR_SHUTDOWN, v);
        chk(v, 8'h70);
        host.rd(ADDR_TIMER2, v);
        chk(v, 8'h00);
        host.rd(ADDR_SRC_LOW, v);
        chk(v, 8'h00);
        soft_i = 1'b1;
        step(1);
        soft_i = 1'b0;
        host.rd(ADDR_SHUTDOWN, v);
        chk(v, 8'h00);
        $display("test resets done");
        host.wr(ADDR_SRC_LOW, 8'h11);
        step(2);
        chk({4'h0, hso}, 8'h03);
        ov_i = 1'b1;
        step(2);
        chk({4'h0, hso}, 8'h00);
        ov_i = 1'b0;
        step(2);
        chk({4'h0, hso}, 8'h00);
        host.wr(ADDR_SHUTDOWN, 8'h10);
        host.wr(ADDR_SRC_LOW, 8'h11);
        uv_i = 1'b1;
        step(2);
        chk({4'h0, hso}, 8'h00);
        uv_i = 1'b0;
        step(2);
        chk({4'h0, hso}, 8'h03);
        host.wr(ADDR_SHUTDOWN, 8'h60);
        ov_i = 1'b1;
        step(2);
        chk({4'h0, hso}, 8'h03);
        ov_i = 1'b0;
        flt_i = 4'h1;
        step(2);
        flt_i = 4'h0;
        host.rd(ADDR_SRC_LOW, v);
        chk(v, 8'h10);
        $display("test supply and faults done");
        // Timer assigned before its on-time is written
        host.wr(ADDR_SRC_HIGH, 8'h31);
        host.wr(ADDR_TIMER2, 8'h60);
        step(3);
        // Switch two stays on from the fault test
        chk({4'h0, hso}, 8'h0e);
        host.wr(ADDR_TIMER2, 8'h00);
        step(3);
        chk({4'h0, hso}, 8'h06);
        host.wr(ADDR_TIMER2, 8'h10);
        step(3);
        chk({7'h0, trun[1]}, 8'h01);
        hi = 0;
        // Two full periods of 400 cycles hold 8 on-cycles in any phase
        repeat (800) begin
            step(1);
            hi += int'(hso[3] === 1'b1);
        end
        chk(8'(hi), 8'h08);
        rs_i = 1'b1;
        step(1);
        rs_i = 1'b0;
        step(2);
        chk({6'h0, trun}, 8'h00);
        $display("test timer done");
        host.wr(ADDR_PWM_RATE, 8'h04);
        host.wr(ADDR_PWM1_DUTY, 8'hff);
        host.wr(ADDR_PWM2_DUTY, 8'h80);
        host.wr(ADDR_TIMER1, 8'h60);
        host.wr(ADDR_SRC_HIGH, 8'h02);
        host.wr(ADDR_SRC_LOW, 8'h54);
        step(2);
        hi = 0;
        lo = 0;
        nr = 0;
        pv = hso[1];
        // Fast PWM: 255 steps of 2 cycles, so 1530 cycles hold three periods
        repeat (1530) begin
            step(1);
            hi += int'(hso[1] === 1'b1);
            nr += int'(hso[1] === 1'b1 && pv === 1'b0);
            lo += int'(hso[0] !== 1'b1 || hso[2] !== 1'b1);
            pv = hso[1];
        end
        chk(8'(nr), 8'h03);
        chk(8'(hi >> 8), 8'h03);
        chk(8'(hi), 8'h00);
        chk({7'h0, lo != 0}, 8'h00);
        $display("test pwm done");
        final_report();
    end
endmodule : testbench
